// ---- hdl/colour_sync_detect.sv ----
// Colour select, strobe edge detect and selective power-disable logic
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "colour_sync_params.svh"

module colour_sync_detect #(
    parameter int DELAY_W = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire colour_sync_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // Scanner controller pins
    input wire logic sample_strobe_pin,
    input wire logic clamp_cycle_pin,
    // Timing and analogue control
    output logic timing_strobe,
    output colour_sync_pkg::mux_ctrl_t mux_ctrl,
    output colour_sync_pkg::power_ctrl_t power_ctrl
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] line_colour_control_ff;
    logic [7:0] strobe_detect_control_ff;
    logic [7:0] selective_disable_ff;
    logic [7:0] mode_ctrl_ff;
    logic [1:0] strobe_sync_ff;
    logic [1:0] clamp_sync_ff;
    logic strobe_prev_ff;
    logic clamp_prev_ff;
    logic [DELAY_W-1:0] delay_cnt_ff;
    logic pending_ff;
    colour_sync_pkg::colour_t cycle_col_ff;

    // ****************************************
    // Field decode
    // ****************************************
    wire line_mode_en = mode_ctrl_ff[`MC_LINE_MODE];
    wire selective_powerdown_en = mode_ctrl_ff[`MC_SELECTIVE_POWERDOWN_EN];
    wire clamp_pin_or_autocycle_sel = line_colour_control_ff[`LC_CYCLE_SEL];
    wire force_input_mux_en = line_colour_control_ff[`LC_FORCE_EN];
    wire internal_clamp_en = line_colour_control_ff[`LC_INT_CLAMP];
    wire [1:0] internal_colour_sel =
        line_colour_control_ff[`LC_INT_COL_LO +: 2];
    wire [1:0] forced_colour_sel =
        line_colour_control_ff[`LC_FORCED_COL_LO +: 2];
    wire strobe_detect_en = strobe_detect_control_ff[`SD_DETECT_EN];
    wire [DELAY_W-1:0] strobe_pulse_delay =
        strobe_detect_control_ff[`SD_DELAY_LO +: DELAY_W];
    wire strobe_edge_polarity = strobe_detect_control_ff[`SD_POLARITY];
    wire [3:0] cell_disable_bits = selective_disable_ff[3:0];

    // ****************************************
    // Colour code mapping
    // ****************************************
    // Reserved code 11 is kept, not remapped: software must avoid it
    function automatic colour_sync_pkg::colour_t to_colour(
        input logic [1:0] code
    );
        to_colour = colour_sync_pkg::colour_t'(code);
    endfunction

    function automatic colour_sync_pkg::colour_t next_colour(
        input colour_sync_pkg::colour_t c
    );
        unique case (c)
            colour_sync_pkg::COL_RED: next_colour = colour_sync_pkg::COL_GREEN;
            colour_sync_pkg::COL_GREEN: next_colour = colour_sync_pkg::COL_BLUE;
            default: next_colour = colour_sync_pkg::COL_RED;
        endcase
    endfunction

    // ****************************************
    // Register port decode
    // ****************************************
    wire wr_lc = req.wr && req.addr == `ADDR_LINE_COLOUR;
    wire wr_sd = req.wr && req.addr == `ADDR_STROBE_DET;
    wire wr_dis = req.wr && req.addr == `ADDR_SEL_DISABLE;
    wire wr_mc = req.wr && req.addr == `ADDR_MODE_CTRL;
    wire [7:0] status_word = {3'h0, pending_ff, 2'h0, cycle_col_ff};
    logic [7:0] nxt_rdata;
    always_comb begin
        unique case (req.addr)
            `ADDR_LINE_COLOUR: nxt_rdata = line_colour_control_ff;
            `ADDR_STROBE_DET: nxt_rdata = strobe_detect_control_ff;
            `ADDR_SEL_DISABLE: nxt_rdata = selective_disable_ff;
            `ADDR_MODE_CTRL: nxt_rdata = mode_ctrl_ff;
            `ADDR_STATUS: nxt_rdata = status_word;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            line_colour_control_ff <= `RST_LINE_COLOUR;
            strobe_detect_control_ff <= `RST_STROBE_DET;
            selective_disable_ff <= `RST_SEL_DISABLE;
            mode_ctrl_ff <= `RST_MODE_CTRL;
            rdata <= 8'h00;
        end else begin
            if (wr_lc) begin
                line_colour_control_ff <= req.wdata;
            end
            if (wr_sd) begin
                // Reserved bits held at zero whatever is written
                strobe_detect_control_ff <= req.wdata & `STROBE_WMASK;
            end
            if (wr_dis) begin
                selective_disable_ff <= req.wdata;
            end
            if (wr_mc) begin
                mode_ctrl_ff <= req.wdata;
            end
            rdata <= req.rd ? nxt_rdata : 8'h00;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strobe_sync_ff <= 2'h0;
            clamp_sync_ff <= 2'h0;
            strobe_prev_ff <= 1'b0;
            clamp_prev_ff <= 1'b0;
        end else begin
            strobe_sync_ff <= {strobe_sync_ff[0], sample_strobe_pin};
            clamp_sync_ff <= {clamp_sync_ff[0], clamp_cycle_pin};
            strobe_prev_ff <= strobe_sync_ff[1];
            clamp_prev_ff <= clamp_sync_ff[1];
        end
    end

    wire strobe_s = strobe_sync_ff[1];
    wire clamp_s = clamp_sync_ff[1];

    // ****************************************
    // Strobe edge detect and delay
    // ****************************************
    wire rise = strobe_s && !strobe_prev_ff;
    wire fall = !strobe_s && strobe_prev_ff;
    wire edge_hit = strobe_edge_polarity ? rise : fall;
    // A new edge restarts the count; no queueing of overlapping edges
    wire load_now = strobe_detect_en && edge_hit;
    wire count_done = pending_ff && delay_cnt_ff == '0;
    wire zero_delay = load_now && strobe_pulse_delay == '0;
    wire nxt_timing = strobe_detect_en
        ? (zero_delay || (count_done && !load_now))
        : strobe_s;

    always_ff @(posedge core_clk) begin
        if (rst || !strobe_detect_en) begin
            pending_ff <= 1'b0;
            delay_cnt_ff <= '0;
        end else if (load_now) begin
            pending_ff <= strobe_pulse_delay != '0;
            delay_cnt_ff <= strobe_pulse_delay - 1'b1;
        end else if (pending_ff) begin
            pending_ff <= delay_cnt_ff != '0;
            delay_cnt_ff <= delay_cnt_ff - 1'b1;
        end
    end

    // ****************************************
    // Colour mux and clamp control
    // ****************************************
    wire auto_cycle = line_mode_en && clamp_pin_or_autocycle_sel;
    wire clamp_rise = clamp_s && !clamp_prev_ff;
    wire [1:0] base_col = auto_cycle ? cycle_col_ff : internal_colour_sel;
    wire forcing = line_mode_en && force_input_mux_en;
    colour_sync_pkg::mux_ctrl_t nxt_mux;
    assign nxt_mux.gain_offset_sel = to_colour(base_col);
    assign nxt_mux.input_sel = forcing ? to_colour(forced_colour_sel)
                                       : to_colour(base_col);
    // Pin clamps except when auto-cycling owns it
    assign nxt_mux.clamp_en = auto_cycle ? internal_clamp_en : clamp_s;
    assign nxt_mux.cycle_advance = auto_cycle && clamp_rise;

    colour_sync_pkg::power_ctrl_t nxt_pwr;
    wire [3:0] dis_eff = selective_powerdown_en ? cell_disable_bits : 4'h0;
    assign nxt_pwr.red_off = dis_eff[0];
    assign nxt_pwr.green_off = dis_eff[1];
    assign nxt_pwr.blue_off = dis_eff[2];
    assign nxt_pwr.adc_off = dis_eff[3];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cycle_col_ff <= colour_sync_pkg::COL_RED;
            timing_strobe <= 1'b0;
            mux_ctrl <= '0;
            power_ctrl <= '0;
        end else begin
            if (!auto_cycle) begin
                cycle_col_ff <= colour_sync_pkg::COL_RED;
            end else if (clamp_rise) begin
                cycle_col_ff <= next_colour(cycle_col_ff);
            end
            timing_strobe <= nxt_timing;
            mux_ctrl <= nxt_mux;
            power_ctrl <= nxt_pwr;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_bypass_follows: assert property (
        @(posedge core_clk) disable iff (rst)
        !strobe_detect_en ##1 !strobe_detect_en |->
            timing_strobe == $past(strobe_s))
        else $error("strobe bypass mismatch");

    a_pulse_one_cycle: assert property (
        @(posedge core_clk) disable iff (rst)
        strobe_detect_en && $past(strobe_detect_en) && timing_strobe
            && $past(strobe_detect_en, 2) |=> !timing_strobe
            || $past(load_now, 1))
        else $error("sync pulse longer than one cycle");

    a_zero_delay: assert property (
        @(posedge core_clk) disable iff (rst)
        load_now && strobe_pulse_delay == '0 |=> timing_strobe)
        else $error("zero delay pulse missing");

    a_delay_one: assert property (
        @(posedge core_clk) disable iff (rst)
        load_now && strobe_pulse_delay == 3'h1 ##1
            (strobe_detect_en && !load_now) |=> timing_strobe)
        else $error("delay of one period wrong");

    a_edge_select: assert property (
        @(posedge core_clk) disable iff (rst)
        strobe_detect_en && strobe_edge_polarity && fall && !pending_ff
            |=> !timing_strobe)
        else $error("wrong edge detected");

    a_clamp_owner: assert property (
        @(posedge core_clk) disable iff (rst)
        auto_cycle |=> mux_ctrl.clamp_en == $past(internal_clamp_en))
        else $error("pin controlled clamp while cycling");

    a_force_line: assert property (
        @(posedge core_clk) disable iff (rst)
        !line_mode_en |=> mux_ctrl.input_sel == mux_ctrl.gain_offset_sel)
        else $error("force mux active outside line mode");

    a_power_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        !selective_powerdown_en |=> power_ctrl == '0)
        else $error("cell disabled without power-down");

    a_cycle_adv: assert property (
        @(posedge core_clk) disable iff (rst)
        auto_cycle && clamp_rise && cycle_col_ff == colour_sync_pkg::COL_RED
            ##1 auto_cycle |-> cycle_col_ff == colour_sync_pkg::COL_GREEN)
        else $error("auto cycle did not advance");

    a_clamp_pin: assert property (
        @(posedge core_clk) disable iff (rst)
        !auto_cycle |=> mux_ctrl.clamp_en == $past(clamp_s))
        else $error("clamp does not follow the pin");

    a_internal_colour: assert property (
        @(posedge core_clk) disable iff (rst)
        !auto_cycle |=>
            mux_ctrl.gain_offset_sel == $past(internal_colour_sel))
        else $error("internal colour not applied");

    a_forced_colour: assert property (
        @(posedge core_clk) disable iff (rst)
        line_mode_en && force_input_mux_en |=>
            mux_ctrl.input_sel == $past(forced_colour_sel))
        else $error("forced colour not applied");

    a_delay_two: assert property (
        @(posedge core_clk) disable iff (rst)
        load_now && strobe_pulse_delay == 3'h2 ##1
            (strobe_detect_en && !load_now)[*2] |=> timing_strobe)
        else $error("delay of two periods wrong");

    a_advance_out: assert property (
        @(posedge core_clk) disable iff (rst)
        auto_cycle && clamp_rise |=> mux_ctrl.cycle_advance)
        else $error("advance pulse missing");

    a_no_cycle_idle: assert property (
        @(posedge core_clk) disable iff (rst)
        !line_mode_en |=> !mux_ctrl.cycle_advance)
        else $error("auto cycle outside line mode");

    a_red_cell: assert property (
        @(posedge core_clk) disable iff (rst)
        selective_powerdown_en |=>
            power_ctrl.red_off == $past(cell_disable_bits[0]))
        else $error("red cell disable wrong");

    a_adc_cell: assert property (
        @(posedge core_clk) disable iff (rst)
        selective_powerdown_en |=>
            power_ctrl.adc_off == $past(cell_disable_bits[3]))
        else $error("converter disable wrong");

    a_rdata_idle: assert property (
        @(posedge core_clk) disable iff (rst)
        !req.rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");

endmodule

// ---- hdl/colour_sync_params.svh ----
// Constants for the colour select and strobe detect register bank
`ifndef COLOUR_SYNC_PARAMS_SVH
`define COLOUR_SYNC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_LINE_COLOUR 4'h0
`define ADDR_STROBE_DET 4'h1
`define ADDR_SEL_DISABLE 4'h2
`define ADDR_MODE_CTRL 4'h3
`define ADDR_STATUS 4'h4

// ****************************************
// Field positions
// ****************************************
`define LC_CYCLE_SEL 1
`define LC_FORCE_EN 2
`define LC_INT_CLAMP 3
`define LC_INT_COL_LO 4
`define LC_FORCED_COL_LO 6
`define SD_DETECT_EN 0
`define SD_DELAY_LO 1
`define SD_POLARITY 4
`define MC_LINE_MODE 0
`define MC_SELECTIVE_POWERDOWN_EN 1

// ****************************************
// Reset values and strobe write mask
// ****************************************
`define RST_LINE_COLOUR 8'h00
`define RST_STROBE_DET 8'h00
`define RST_SEL_DISABLE 8'h00
`define RST_MODE_CTRL 8'h00
`define STROBE_WMASK 8'h1F

`endif

// ---- hdl/colour_sync_pkg.sv ----
// Types for the colour select and strobe detect register bank
package colour_sync_pkg;

    typedef enum logic [1:0] {
        COL_RED = 2'h0,
        COL_GREEN = 2'h1,
        COL_BLUE = 2'h2,
        COL_RSVD = 2'h3
    } colour_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        colour_t input_sel;
        colour_t gain_offset_sel;
        logic clamp_en;
        logic cycle_advance;
    } mux_ctrl_t;

    typedef struct packed {
        logic red_off;
        logic green_off;
        logic blue_off;
        logic adc_off;
    } power_ctrl_t;

endpackage

// ---- verif/scanner_ctrl_model.sv ----
// Scanner controller model driving the strobe and clamp/cycle pins
`timescale 1ns/100ps

module scanner_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Levels asked for by the bench
    input wire logic strobe_level,
    input wire logic clamp_level,
    // Pins toward the block
    output logic sample_strobe_pin,
    output logic clamp_cycle_pin
);
    // Controller moves its pins on its own edge, one cycle after asked
    always @(posedge core_clk) begin
        sample_strobe_pin <= strobe_level;
        clamp_cycle_pin <= clamp_level;
    end
endmodule

// ---- verif/colour_select_and_sync_detect_test.sv ----
// Testbench for the colour select and strobe detect register bank
`timescale 1ns/100ps
`include "colour_sync_params.svh"

module colour_select_and_sync_detect_test;
    logic core_clk;
    logic rst;
    colour_sync_pkg::reg_req_t req;
    logic [7:0] rdata;
    logic sample_strobe_pin;
    logic clamp_cycle_pin;
    logic strobe_level = 1'b0;
    logic clamp_level = 1'b0;
    logic timing_strobe;
    colour_sync_pkg::mux_ctrl_t mux_ctrl;
    colour_sync_pkg::power_ctrl_t power_ctrl;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int advances = 0;
    logic [7:0] v;

    colour_sync_detect colour_sync_detect_inst (.core_clk(core_clk),
        .rst(rst), .req(req), .rdata(rdata),
        .sample_strobe_pin(sample_strobe_pin),
        .clamp_cycle_pin(clamp_cycle_pin), .timing_strobe(timing_strobe),
        .mux_ctrl(mux_ctrl), .power_ctrl(power_ctrl));
    scanner_ctrl_model scanner_ctrl_model_inst (.core_clk(core_clk),
        .strobe_level(strobe_level), .clamp_level(clamp_level),
        .sample_strobe_pin(sample_strobe_pin),
        .clamp_cycle_pin(clamp_cycle_pin));

    // ****************************************
    // Clock, watchdog and shared tasks
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Whole run needs about 800 cycles; ceiling leaves ample margin
    always @(posedge core_clk) begin
        cycles++;
        if (mux_ctrl.cycle_advance === 1'b1) advances++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Pin requests; the controller model moves its pins an edge later
    task automatic set_strobe(input logic lvl);
        @(posedge core_clk);
        strobe_level <= lvl;
    endtask

    task automatic set_clamp(input logic lvl);
        @(posedge core_clk);
        clamp_level <= lvl;
    endtask

    // Wide pulses mimic a slow controller
    task automatic pulse_clamp(input int width);
        set_clamp(1'b1);
        repeat (width) @(posedge core_clk);
        clamp_level <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs;
        rd_reg(`ADDR_STROBE_DET, v);
        check(v, 8'h00);
        wr_reg(`ADDR_LINE_COLOUR, 8'h9E);
        wr_reg(`ADDR_STROBE_DET, 8'h1F);
        wr_reg(4'hF, 8'hFF);
        rd_reg(`ADDR_LINE_COLOUR, v);
        check(v, 8'h9E);
        rd_reg(`ADDR_STROBE_DET, v);
        check(v, 8'h1F);
        rd_reg(4'hF, v);
        check(v, 8'h00);
        wr_reg(`ADDR_STROBE_DET, 8'h00);
        $display("register test done");
    endtask

    task automatic test_mux;
        logic [1:0] fc;
        for (int c = 0; c < 3; c++) begin
            fc = 2'((c + 1) % 3);
            wr_reg(`ADDR_MODE_CTRL, 8'h01);
            wr_reg(`ADDR_LINE_COLOUR, {fc, 2'(c), 4'h4});
            tick(4);
            check(8'(mux_ctrl.input_sel), 8'(fc));
            check(8'(mux_ctrl.gain_offset_sel), 8'(c));
            wr_reg(`ADDR_MODE_CTRL, 8'h00);
            tick(4);
            check(8'(mux_ctrl.input_sel), 8'(c));
        end
        $display("mux test done");
    endtask

    task automatic test_clamp;
        wr_reg(`ADDR_MODE_CTRL, 8'h01);
        wr_reg(`ADDR_LINE_COLOUR, 8'h00);
        set_clamp(1'b1);
        tick(5);
        check(8'(mux_ctrl.clamp_en), 8'h01);
        set_clamp(1'b0);
        tick(5);
        check(8'(mux_ctrl.clamp_en), 8'h00);
        wr_reg(`ADDR_LINE_COLOUR, 8'h0A);
        tick(5);
        check(8'(mux_ctrl.clamp_en), 8'h01);
        check(8'(mux_ctrl.gain_offset_sel), 8'h00);
        advances = 0;
        for (int k = 1; k < 5; k++) begin
            pulse_clamp(k);
            tick(6);
            check(8'(mux_ctrl.gain_offset_sel), 8'(k % 3));
        end
        check(8'(advances), 8'h04);
        rd_reg(`ADDR_STATUS, v);
        check(v, 8'h01);
        wr_reg(`ADDR_LINE_COLOUR, 8'h02);
        set_clamp(1'b1);
        tick(5);
        check(8'(mux_ctrl.clamp_en), 8'h00);
        wr_reg(`ADDR_MODE_CTRL, 8'h00);
        tick(5);
        check(8'(mux_ctrl.clamp_en), 8'h01);
        set_clamp(1'b0);
        $display("clamp test done");
    endtask

    task automatic test_strobe_off;
        wr_reg(`ADDR_STROBE_DET, 8'h1E);
        set_strobe(1'b1);
        tick(5);
        check(8'(timing_strobe), 8'h01);
        set_strobe(1'b0);
        tick(5);
        check(8'(timing_strobe), 8'h00);
        $display("strobe pass-through test done");
    endtask

    task automatic test_detect;
        int n;
        int hits;
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 8; d++) begin
                wr_reg(`ADDR_STROBE_DET, {3'h0, 1'(p), 3'(d), 1'b1});
                set_strobe(!p[0]);
                tick(12);
                set_strobe(p[0]);
                n = 0;
                do begin
                    tick(1);
                    n++;
                end while (timing_strobe !== 1'b1 && n < 15);
                check(8'(n), 8'(4 + d));
                tick(1);
                check(8'(timing_strobe), 8'h00);
                set_strobe(!p[0]);
                hits = 0;
                repeat (14) begin
                    tick(1);
                    if (timing_strobe !== 1'b0) hits++;
                end
                check(8'(hits), 8'h00);
            end
        end
        $display("edge detect test done");
    endtask

    task automatic test_power;
        wr_reg(`ADDR_MODE_CTRL, 8'h02);
        for (int b = 0; b < 4; b++) begin
            wr_reg(`ADDR_SEL_DISABLE, 8'(1 << b));
            tick(3);
            check(8'(power_ctrl), 8'(4'h8 >> b));
        end
        $display("power disable test done");
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        test_regs();
        test_mux();
        test_clamp();
        test_strobe_off();
        test_detect();
        test_power();
        report_and_stop();
    end
endmodule
